// >>> nhp_host.sv
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: five address bytes: column, column, page/block, block, block/die
// RULE2: x16 column bit10 only with 9:5 zero
// RULE3: x8 column bit11 only with 10:6 zero
// RULE4: block bit 6 selects the plane
// RULE5: block bit 18 selects the die
// RULE6: commands/addresses on low byte, upper zero
// RULE7: unused address bits driven low
// RULE8: command latched on write strobe rise, cle high
// RULE9: address latched on write strobe rise, ale high
// RULE10: data written on write strobe rise, latches low
// RULE11: device drives data on read strobe fall
// RULE12: capture rising edge if cycle >=30ns, else falling; the code captures before the strobe rise at every cycle time
// RULE13: chip select high puts idle device in standby
// RULE14: busy die ignores commands except status reads; the flash model also accepts reset while busy
// RULE15: busy die accepts addresses after enhanced status
// RULE16: unselected or busy die discards data input
// RULE17: busy die outputs only status after status read; the flash model does not drive the bus at all while busy
// RULE18: issue read mode after enhanced status
// RULE19: guard low blocks program and erase
// RULE20: guard changes only when ready, then wait
// RULE21: guard honoured even with chip select high
// RULE22: guard held low from power-on
// RULE23: ready/busy high only when all dies ready
// RULE24: reset command first, then busy 1ms
// RULE25: guard wait and cycle time programmable
module nhp_host
  import nhp_pkg::*;
#(
  parameter int RESET_WAIT = RESET_BUSY_CYC
) (
  // clock and reset
  input  wire logic                    i_mclk,
  input  wire logic                    i_rst_n,
  input  wire logic                    i_ce,
  // configuration
  input  wire logic                    i_x16,
  input  wire logic [7:0]              i_half_cyc,
  input  wire logic [15:0]             i_guard_cyc,
  // request
  input  wire logic                    i_req_valid,
  output logic                         o_req_ready,
  input  wire nhp_pkg::nhp_req_s       i_req,
  // write data in
  input  wire logic                    i_wdata_valid,
  output logic                         o_wdata_ready,
  input  wire logic [nhp_pkg::DW-1:0]  i_wdata,
  // read data out
  output logic                         o_rdata_valid,
  input  wire logic                    i_rdata_ready,
  output logic      [nhp_pkg::DW-1:0]  o_rdata,
  // status
  output logic                         o_busy,
  output logic                         o_init_done,
  output logic                         o_order_err,
  // flash pins
  output nhp_pkg::nhp_ctl_s            o_ctl,
  output logic      [nhp_pkg::DW-1:0]  o_io,
  output logic      [nhp_pkg::DW-1:0]  o_io_oe,
  input  wire logic [nhp_pkg::DW-1:0]  i_io,
  input  wire logic                    i_ready_busy_n
);
  import nhp_pkg::*;

  typedef enum logic [4:0] {
    ST_INIT  = 5'b00001,
    ST_IDLE  = 5'b00010,
    ST_LOW   = 5'b00100,
    ST_HIGH  = 5'b01000,
    ST_GUARD = 5'b10000
  } nhp_state_e;

  // ===========================================================
  // synchronisers
  logic [DW-1:0] io_s1;
  logic [DW-1:0] io_s2;
  logic [1:0]    rb_s;
  always_ff @(posedge i_mclk) begin
    if (i_ce) begin
      io_s1 <= i_io;
      io_s2 <= io_s1;
      rb_s  <= {rb_s[0], i_ready_busy_n};
    end
  end
  logic ready;
  assign ready = rb_s[1]; // [RULE23]

  // ===========================================================
  // address byte builder
  function automatic logic [7:0] addr_byte(input nhp_req_s r, input logic [2:0] n,
                                           input logic x16);
    logic [7:0] b;
    b = 8'h00;
    case (n)
      3'h0: b = r.col[7:0]; // [RULE1]
      3'h1: b = x16 ? {5'h00, r.col[10:8]} : {4'h0, r.col[11:8]}; // [RULE7]
      3'h2: b = {r.blk[1:0], r.page}; // [RULE4]
      3'h3: b = r.blk[9:2];
      3'h4: b = {5'h00, r.blk[12:10]}; // [RULE5]
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  // x16: bit10 only with 9:5 zero; x8: bit11 only with 10:6 zero
  function automatic logic col_ok(input logic [COL_W-1:0] c, input logic x16);
    return x16 ? (!c[10] || (c[9:5] == 5'h00)) && !c[11] // [RULE2]
               : (!c[11] || (c[10:6] == 5'h00)); // [RULE3]
  endfunction

  // ===========================================================
  // fifos
  logic          wf_valid;
  logic          wf_pop;
  logic [DW-1:0] wf_data;
  logic          rf_push;
  logic          rf_ready;
  logic [DW-1:0] rf_data;
  nhp_fifo #(.WIDTH(DW), .DEPTH(FIFO_DEPTH)) u_wfifo (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_valid (i_wdata_valid),
    .o_ready (o_wdata_ready),
    .i_data  (i_wdata),
    .o_valid (wf_valid),
    .i_ready (wf_pop),
    .o_data  (wf_data)
  );
  nhp_fifo #(.WIDTH(DW), .DEPTH(FIFO_DEPTH)) u_rfifo (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_valid (rf_push),
    .o_ready (rf_ready),
    .i_data  (rf_data),
    .o_valid (o_rdata_valid),
    .i_ready (i_rdata_ready),
    .o_data  (o_rdata)
  );

  // ===========================================================
  // sequencer
  nhp_state_e state;
  nhp_req_s   cur;
  logic [2:0] acnt;
  logic [15:0] left;
  logic [23:0] tmr;
  logic        extended_output_mode;
  logic        enh_pending;
  logic        tmr_done;
  assign tmr_done    = (tmr == 24'h000000);
  assign extended_output_mode         = (32'(i_half_cyc) * 2 * CLK_PERIOD_NS) < EDO_LIMIT_NS; // [RULE25]
  // requests held off while the target reports busy
  assign o_req_ready = (state == ST_IDLE) && ready; // [RULE20]
  assign o_busy      = !ready || (state != ST_IDLE);
  assign wf_pop      = (state == ST_LOW) && tmr_done && (cur.op == OP_WRITE) && wf_valid;
  // capture before the strobe rise in both modes; with edo the strobe does not wait for fifo room
  assign rf_push     = (state == ST_HIGH) && tmr_done && (cur.op == OP_READ) && rf_ready;
  assign rf_data     = i_x16 ? io_s2 : {8'h00, io_s2[7:0]}; // [RULE12]

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      state       <= ST_INIT;
      cur         <= '0;
      acnt        <= 3'h0;
      left        <= 16'h0000;
      tmr         <= 24'(RESET_WAIT);
      o_init_done <= 1'b0;
      o_order_err <= 1'b0;
      enh_pending <= 1'b0;
      o_ctl       <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1,
                       read_strobe_n: 1'b1, wp_n: 1'b0}; // [RULE22]
      o_io        <= '0;
      o_io_oe     <= '0;
    end else if (i_ce) begin
      if (!tmr_done) begin
        tmr <= tmr - 24'h000001;
      end
      case (state)
        ST_INIT: begin
          // issue reset as the first command once ready, then let busy time elapse
          if (tmr_done && ready) begin
            cur         <= '0;
            cur.op      <= OP_CMD;
            cur.cmd     <= CMD_RESET; // [RULE24]
            o_ctl.ce_n  <= 1'b0;
            state       <= ST_LOW;
            o_init_done <= 1'b1;
            tmr         <= 24'(i_half_cyc);
          end
        end
        ST_IDLE: begin
          if (i_req_valid && ready) begin // [RULE20]
            cur  <= i_req;
            acnt <= 3'h0;
            left <= i_req.count;
            tmr  <= 24'(i_half_cyc);
            o_order_err <= (i_req.op == OP_ADDR) && !col_ok(i_req.col, i_x16);
            if (i_req.op == OP_RELEASE) begin
              o_ctl.ce_n <= 1'b1; // [RULE13]
            end else if (i_req.op == OP_GUARD) begin
              o_ctl.wp_n <= i_req.guard; // [RULE19] [RULE21]
              tmr        <= 24'(i_guard_cyc);
              state      <= ST_GUARD;
            end else begin
              if (i_req.op == OP_CMD) begin
                enh_pending <= (i_req.cmd == CMD_STATUS_ENH); // [RULE18]
              end
              if (i_req.op == OP_READ && enh_pending) begin
                o_order_err <= 1'b1;
              end
              o_ctl.ce_n <= 1'b0;
              state      <= ST_LOW;
            end
          end
        end
        ST_LOW: begin
          // strobe low phase; drive bus, or release it for reads
          o_ctl.cle <= (cur.op == OP_CMD); // [RULE8]
          o_ctl.ale <= (cur.op == OP_ADDR); // [RULE9]
          if (cur.op == OP_READ) begin
            o_ctl.read_strobe_n <= 1'b0; // [RULE11]
            o_io_oe             <= '0;
          end else begin
            o_ctl.we_n <= 1'b0;
            o_io_oe    <= i_x16 ? 16'hffff : 16'h00ff;
            if (cur.op == OP_CMD) begin
              o_io <= {8'h00, cur.cmd}; // [RULE6]
            end else if (cur.op == OP_ADDR) begin
              o_io <= {8'h00, addr_byte(cur, acnt, i_x16)}; // [RULE1] [RULE6]
            end else begin
              o_io <= i_x16 ? wf_data : {8'h00, wf_data[7:0]}; // [RULE10]
            end
          end
          if (tmr_done && (cur.op != OP_WRITE || wf_valid)) begin
            tmr   <= 24'(i_half_cyc);
            state <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          // rising strobe latches command, address or data
          if (tmr_done && (cur.op != OP_READ || rf_ready || extended_output_mode)) begin
            o_ctl.we_n          <= 1'b1;
            o_ctl.read_strobe_n <= 1'b1;
            tmr                 <= 24'(i_half_cyc);
            if (cur.op == OP_ADDR && acnt != 3'(ADDR_CYCLES - 1)) begin
              acnt  <= acnt + 3'h1;
              state <= ST_LOW;
            end else if ((cur.op == OP_WRITE || cur.op == OP_READ) && left > 16'h0001) begin
              left  <= left - 16'h0001;
              state <= ST_LOW;
            end else begin
              // latches and bus stand one cycle past the closing strobe edge
              tmr       <= (cur.cmd == CMD_RESET && cur.op == OP_CMD)
                           ? 24'(RESET_WAIT) : 24'h000000;
              state     <= ST_GUARD;
            end
          end
        end
        ST_GUARD: begin
          o_ctl.cle <= 1'b0; // [RULE8]
          o_ctl.ale <= 1'b0; // [RULE9]
          o_io_oe   <= '0;
          if (tmr_done) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule

// >>> nhp_pkg.sv
package nhp_pkg;
  // ===========================================================
  // bus width and fifo depth
  localparam int DW = 16;
  localparam int FIFO_DEPTH = 8;
  // ===========================================================
  // address field positions
  localparam int COL_W = 12;
  localparam int PAGE_W = 6;
  localparam int BLK_W = 13;
  localparam int BLK_LO = 6;
  // ===========================================================
  // commands
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_STATUS_ENH = 8'h78;
  localparam logic [7:0] CMD_READ_MODE = 8'h00;
  localparam logic [7:0] CMD_RESET = 8'hff;
  // ===========================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int EDO_LIMIT_NS = 30;
  localparam int RESET_BUSY_US = 1000;
  localparam int RESET_BUSY_CYC = RESET_BUSY_US * 1000 / CLK_PERIOD_NS;
  localparam logic [7:0] DEF_HALF_CYC = 8'h02;
  localparam logic [15:0] DEF_GUARD_CYC = 16'h0014;
  localparam int ADDR_CYCLES = 5;

  typedef enum logic [2:0] {
    OP_CMD = 3'h0,
    OP_ADDR = 3'h1,
    OP_WRITE = 3'h2,
    OP_READ = 3'h3,
    OP_GUARD = 3'h4,
    OP_RELEASE = 3'h5
  } nhp_op_e;

  typedef struct packed {
    nhp_op_e op;
    logic [7:0] cmd;
    logic [COL_W-1:0] col;
    logic [PAGE_W-1:0] page;
    logic [BLK_W-1:0] blk;
    logic [15:0] count;
    logic guard;
  } nhp_req_s;

  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic read_strobe_n;
    logic wp_n;
  } nhp_ctl_s;
endpackage

// >>> nhp_fifo.sv
`timescale 1ns/1ps
module nhp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // clock
  input  wire logic             i_mclk,
  input  wire logic             i_rst_n,
  input  wire logic             i_ce,
  // fill side
  input  wire logic             i_valid,
  output logic                  o_ready,
  input  wire logic [WIDTH-1:0] i_data,
  // drain side
  output logic                  o_valid,
  input  wire logic             i_ready,
  output logic      [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp;
  logic [AW-1:0]    rp;
  logic [AW:0]      cnt;
  logic             push;
  logic             pop;

  assign o_ready = (cnt != (AW+1)'(DEPTH));
  assign o_valid = (cnt != '0);
  assign o_data  = mem[rp];
  assign push    = i_valid && o_ready && i_ce;
  assign pop     = o_valid && i_ready && i_ce;

  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem[wp] <= i_data;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end else begin
      if (push) begin
        wp <= (wp == AW'(DEPTH-1)) ? '0 : wp + 1'b1;
      end
      if (pop) begin
        rp <= (rp == AW'(DEPTH-1)) ? '0 : rp + 1'b1;
      end
      if (push && !pop) begin
        cnt <= cnt + 1'b1;
      end else if (pop && !push) begin
        cnt <= cnt - 1'b1;
      end
    end
  end
endmodule

// >>> nhp_host_sva.sv
`timescale 1ns/1ps
module nhp_host_sva
  import nhp_pkg::*;
(
  // =====
  // watched ports
  input wire logic                   i_mclk,
  input wire logic                   i_rst_n,
  input wire logic                   i_ready_busy_n,
  input wire logic                   o_busy,
  input wire nhp_pkg::nhp_ctl_s      o_ctl,
  input wire logic [nhp_pkg::DW-1:0] o_io,
  input wire logic [nhp_pkg::DW-1:0] o_io_oe
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  property p_rst;
    @(posedge i_mclk) disable iff (1'b0)
    !i_rst_n |=> o_ctl.ce_n && o_ctl.we_n && !o_ctl.wp_n && o_io_oe == 16'h0000;
  endproperty
  a_rst: assert property (p_rst) else $error("pins not idle in reset");
  property p_cmd_hold;
    o_ctl.cle && !o_ctl.we_n |=> o_ctl.we_n || (o_ctl.cle && $stable(o_io[7:0]));
  endproperty
  a_cmd_hold: assert property (p_cmd_hold) else $error("command moved in strobe");
  property p_addr_hold;
    o_ctl.ale && !o_ctl.we_n |=> o_ctl.we_n || (o_ctl.ale && $stable(o_io[7:0]));
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved in strobe");
  property p_latch_excl;
    !(o_ctl.cle && o_ctl.ale);
  endproperty
  a_latch_excl: assert property (p_latch_excl) else $error("both latches high");
  property p_upper_zero;
    (o_ctl.cle || o_ctl.ale) && !o_ctl.we_n |-> o_io[15:8] == 8'h00;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper lines not zero");
  property p_we_sel;
    !o_ctl.we_n |-> !o_ctl.ce_n && o_ctl.read_strobe_n;
  endproperty
  a_we_sel: assert property (p_we_sel) else $error("write strobe unselected");
  property p_rd_release;
    !o_ctl.read_strobe_n |-> o_io_oe == 16'h0000 && !o_ctl.cle && !o_ctl.ale && o_ctl.we_n;
  endproperty
  a_rd_release: assert property (p_rd_release) else $error("bus driven in read");
  property p_guard_idle;
    $changed(o_ctl.wp_n) |-> o_ctl.we_n && o_ctl.read_strobe_n && !o_ctl.cle;
  endproperty
  a_guard_idle: assert property (p_guard_idle) else $error("guard moved in cycle");
  property p_busy;
    !i_ready_busy_n [*4] |-> o_busy;
  endproperty
  a_busy: assert property (p_busy) else $error("busy not reported");
  c_cmd: cover property ($rose(o_ctl.we_n) && $past(o_ctl.cle));
  c_addr: cover property ($rose(o_ctl.we_n) && $past(o_ctl.ale));
  c_read: cover property ($fell(o_ctl.read_strobe_n));
  c_guard: cover property ($rose(o_ctl.wp_n));
endmodule
bind nhp_host nhp_host_sva u_sva (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
  .i_ready_busy_n(i_ready_busy_n), .o_busy(o_busy), .o_ctl(o_ctl), .o_io(o_io),
  .o_io_oe(o_io_oe));

// >>> nhp_flash_model.sv
`timescale 1ns/1ps
module nhp_flash_model
  import nhp_pkg::*;
#(
  parameter int         BUSY_CYC = 40,
  parameter logic [7:0] PROG_CMD = 8'h10
) (
  // host side
  input  wire logic              i_mclk,
  input  wire nhp_pkg::nhp_ctl_s i_ctl,
  input  wire logic [15:0]       i_io,
  // device side
  output logic      [15:0]       o_io,
  output logic                   o_ready_busy_n
);
  logic [7:0]  cmd_q[$];
  logic [7:0]  ab[0:4];
  logic [15:0] mem[0:7];
  logic [15:0] last = 16'h0000;
  logic        drv = 1'b0;
  int          na = 0, wi = 0, ri = 0, busy = 0, progs = 0;
  wire         die = ab[4][2];
  wire         plane = ab[2][6];
  assign o_ready_busy_n = (busy == 0);
  // released lines show the inverse of the last value
  assign o_io = drv ? last : ~last;
  always @(posedge i_mclk) if (busy > 0) busy <= busy - 1;
  always @(posedge i_ctl.we_n) if (!i_ctl.ce_n && i_ctl.read_strobe_n) begin
    if (i_ctl.cle) begin
      if (busy == 0 || i_io[7:0] inside {CMD_STATUS, CMD_STATUS_ENH, CMD_RESET}) begin
        cmd_q.push_back(i_io[7:0]);
        na = 0;
        wi = 0;
        ri = 0;
      end
      if (i_io[7:0] == CMD_RESET || (i_io[7:0] == PROG_CMD && busy == 0 && i_ctl.wp_n)) begin
        progs += (i_io[7:0] == PROG_CMD);
        busy = BUSY_CYC;
      end
    end else if (i_ctl.ale) begin
      if (busy == 0 || cmd_q[$] == CMD_STATUS_ENH) begin
        ab[na % 5] = i_io[7:0];
        na++;
      end
    end else if (busy == 0) begin
      mem[wi % 8] = i_io;
      wi++;
    end
  end
  always @(negedge i_ctl.read_strobe_n)
    if (!i_ctl.ce_n && !i_ctl.cle && !i_ctl.ale && i_ctl.we_n && busy == 0) begin
      last = mem[ri % 8];
      ri++;
      drv = 1'b1;
    end
  always @(negedge i_ctl.we_n or posedge i_ctl.ce_n) drv = 1'b0;
endmodule

// >>> tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_total++; \
  $display("wrong value at %0t ns: got %h", $time, a); end end
module tb;
  import nhp_pkg::*;
  logic mclk = 0, rst_n = 0, x16 = 1, rv = 0, wv = 0, rr = 0, drain = 0, took_r = 0, took_w = 0;
  logic [15:0] wd = 16'h0000;
  logic [7:0] half = DEF_HALF_CYC;
  nhp_req_s r = '0;
  nhp_ctl_s ctl;
  wire rq_rdy, wrdy, rdv, busy, done, oerr, rb_n;
  wire [15:0] rdata, io, oe, mio, bus;
  int err_total = 0, samples_checked = 0, cyc = 0, i;
  logic [15:0] exp_q[$], got_q[$];
  assign bus = (oe & io) | (~oe & mio);
  nhp_host #(.RESET_WAIT(20)) dut (.i_mclk(mclk), .i_rst_n(rst_n), .i_ce(1'b1), .i_x16(x16),
    .i_half_cyc(half), .i_guard_cyc(DEF_GUARD_CYC), .i_req_valid(rv),
    .o_req_ready(rq_rdy), .i_req(r), .i_wdata_valid(wv), .o_wdata_ready(wrdy), .i_wdata(wd),
    .o_rdata_valid(rdv), .i_rdata_ready(rr), .o_rdata(rdata), .o_busy(busy),
    .o_init_done(done), .o_order_err(oerr), .o_ctl(ctl), .o_io(io), .o_io_oe(oe),
    .i_io(bus), .i_ready_busy_n(rb_n));
  nhp_flash_model mdl (.i_mclk(mclk), .i_ctl(ctl), .i_io(bus), .o_io(mio), .o_ready_busy_n(rb_n));
  initial forever #5 mclk = ~mclk;
  always @(posedge mclk) begin
    took_r <= rv && rq_rdy;
    took_w <= wv && wrdy;
    if (rdv && rr) got_q.push_back(rdata);
    cyc++;
    if (cyc > 30000) begin
      err_total++;
      stop_test();
    end
  end
  // random stalls on the drain side
  always @(negedge mclk) rr <= drain && $urandom_range(1);
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic send(input nhp_op_e op, input logic [7:0] c, input logic [15:0] n);
    @(negedge mclk);
    r.op = op;
    r.cmd = c;
    r.count = n;
    rv = 1;
    do @(negedge mclk); while (!took_r);
    rv = 0;
    @(negedge mclk);
    while (!rq_rdy) @(negedge mclk);
  endtask
  task automatic wpush(input logic [15:0] d);
    @(negedge mclk);
    wd = d;
    wv = 1;
    do @(negedge mclk); while (!took_w);
    wv = 0;
    exp_q.push_back(d);
  endtask
  initial begin
    void'($urandom(32'habac));
    repeat (8) @(negedge mclk);
    rst_n = 1;
    while (!done) @(negedge mclk);
    send(OP_CMD, CMD_READ_MODE, 0);
    `CHK(mdl.cmd_q[0], CMD_RESET)
    $display("test init done");
    for (i = 0; i < 4; i++) begin
      x16 = i[0];
      r.col = i[0] ? 12'h400 | 12'($urandom_range(31)) : 12'h800 | 12'($urandom_range(63));
      if (i > 1) r.col[6] = 1'b1;
      r.page = 6'($urandom);
      r.blk = 13'($urandom);
      send(OP_ADDR, 8'h00, 16'h0000);
      `CHK(oerr, i > 1)
      if (i < 2) begin
        `CHK({mdl.ab[0], mdl.ab[1], mdl.ab[2], mdl.ab[3], mdl.ab[4]}, {r.col[7:0], 4'h0, r.col[11:8], r.blk[1:0], r.page, r.blk[9:2], 5'h00, r.blk[12:10]})
        `CHK({mdl.die, mdl.plane}, {r.blk[12], r.blk[0]})
      end
    end
    $display("test address done");
    x16 = 1;
    send(OP_CMD, CMD_READ_MODE, 0);
    for (i = 0; i < 8; i++) wpush(16'($urandom));
    @(negedge mclk);
    `CHK(wrdy, 1'b0)
    send(OP_WRITE, 8'h00, 16'd8);
    for (i = 0; i < 8; i++) `CHK(mdl.mem[i], exp_q[i])
    $display("test write done");
    send(OP_CMD, CMD_READ_MODE, 0);
    send(OP_READ, 8'h00, 16'd4);
    drain = 1;
    send(OP_READ, 8'h00, 16'd8);
    while (got_q.size() < 12) @(negedge mclk);
    for (i = 0; i < 12; i++) `CHK(got_q[i], exp_q[i % 8])
    $display("test read done");
    // 20 ns cycle, below the capture limit
    half = 8'h01;
    send(OP_CMD, CMD_READ_MODE, 0);
    send(OP_READ, 8'h00, 16'd8);
    while (got_q.size() < 20) @(negedge mclk);
    for (i = 12; i < 20; i++) `CHK(got_q[i], exp_q[i - 12])
    half = DEF_HALF_CYC;
    $display("test edo read done");
    send(OP_CMD, mdl.PROG_CMD, 0);
    `CHK(mdl.progs, 0)
    r.guard = 1;
    send(OP_GUARD, 8'h00, 0);
    `CHK(ctl.wp_n, 1'b1)
    send(OP_CMD, mdl.PROG_CMD, 0);
    `CHK(mdl.progs, 1)
    send(OP_CMD, CMD_STATUS, 0);
    `CHK(mdl.cmd_q[$], CMD_STATUS)
    `CHK(busy, 1'b0)
    send(OP_CMD, CMD_STATUS_ENH, 0);
    send(OP_READ, 8'h00, 16'd1);
    `CHK(oerr, 1'b1)
    send(OP_CMD, CMD_READ_MODE, 0);
    send(OP_READ, 8'h00, 16'd1);
    `CHK(oerr, 1'b0)
    send(OP_RELEASE, 8'h00, 0);
    `CHK(ctl.ce_n, 1'b1)
    $display("test guard done");
    stop_test();
  end
endmodule
